/* pkg/dsk_pkg.sv */
package dsk_pkg;
	// opcode low five bits; the flag bits above them are ignored on decode, except bit 7, which relative seek requires
	localparam logic [4:0] OPC_RD_DEL  = 5'h0C;
	localparam logic [4:0] OPC_RD_ID   = 5'h0A;
	localparam logic [4:0] OPC_RD_TRK  = 5'h02;
	localparam logic [4:0] OPC_RECAL   = 5'h07;
	localparam logic [4:0] OPC_RSEEK   = 5'h0F;
	localparam logic [4:0] OPC_SCAN_EQ = 5'h11;
	localparam logic [4:0] OPC_SCAN_HE = 5'h1D;

	// flag and field positions in the command bytes
	localparam int BIT_MT    = 7;
	localparam int BIT_DD    = 6;
	localparam int BIT_SK    = 5;
	localparam int BIT_DIR   = 6;
	localparam int BIT_RSEEK = 7;
	localparam int BIT_HEAD  = 2;

	// byte slots in the command buffer
	localparam int P_UNIT  = 1;
	localparam int P_COUNT = 2;
	localparam int P_TRACK = 2;
	localparam int P_HEAD  = 3;
	localparam int P_SECT  = 4;
	localparam int P_SIZE  = 5;

	// command lengths in bytes, result length and header length
	localparam logic [3:0] LEN_LONG  = 4'h9;
	localparam logic [3:0] LEN_DRIVE = 4'h2;
	localparam logic [3:0] LEN_RSEEK = 4'h3;
	localparam logic [3:0] RES_FIRST = 4'h0;
	localparam logic [3:0] RES_LAST  = 4'h6;
	localparam logic [3:0] RES_CHRN  = 4'h3;
	localparam logic [1:0] ID_LAST   = 2'h3;

	// status bits owned by this block
	localparam int ST2_SCAN_HIT  = 3;
	localparam int ST2_SCAN_MISS = 2;

	// step limit and step timing
	localparam logic [7:0] RECAL_MAX    = 8'hFF;
	localparam int unsigned CLK_NS       = 100;
	localparam int unsigned STEP_TIME_NS = 3000000;
	localparam int unsigned STEP_CYCLES  = (STEP_TIME_NS + CLK_NS - 1) / CLK_NS;

	// data buffer shape
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_PARAM = 5'h02,
		S_EXEC  = 5'h04,
		S_STEP  = 5'h08,
		S_RES   = 5'h10
	} dsk_state_type;

	typedef enum logic [2:0] {
		K_RD_DEL  = 3'h0,
		K_RD_ID   = 3'h1,
		K_RD_TRK  = 3'h2,
		K_RECAL   = 3'h3,
		K_RSEEK   = 3'h4,
		K_SCAN_EQ = 3'h5,
		K_SCAN_HE = 3'h6,
		K_BAD     = 3'h7
	} dsk_kind_type;

	typedef struct packed {
		logic       head_select;
		logic [1:0] drive_unit_select;
		logic       step_pulse;
		logic       step_dir;
		logic       exec_active;
		logic       double_density_select;
		logic       multi_track_flag;
		logic       skip_deleted_flag;
	} dsk_drive_type;

	typedef struct packed {
		dsk_state_type   st;
		dsk_kind_type    kind;
		logic [3:0]      idx;
		logic [8:0][7:0] prm;
		logic [3:0][7:0] id;
		logic [1:0]      id_n;
		logic [15:0]     step_cnt;
		logic [7:0]      steps;
		logic [3:0][7:0] trk;
		logic            dir;
		logic            step_o;
		logic            done;
		logic            miss;
		logic            seek_end;
		logic [7:0]      res_q;
	} dsk_core_type;
endpackage

/* verilog/dsk_fifo.sv */
`timescale 1ns/1ps
module dsk_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  logic             clk,
	input  logic             rst_b,
	input  logic             in_valid,
	input  logic [WIDTH-1:0] in_data,
	output logic             in_ready,
	output logic             out_valid,
	output logic [WIDTH-1:0] out_data,
	input  logic             out_ready,
	output logic             empty
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
		logic                        ov;
		logic [WIDTH-1:0]            od;
	} dsk_fifo_type;

	dsk_fifo_type q, d;
	logic         wr;
	logic         ld;

	// handshakes; output stage counts as one extra slot
	assign in_ready  = q.cnt != (AW + 1)'(DEPTH);
	assign out_valid = q.ov;
	assign out_data  = q.od;
	assign empty     = (q.cnt == '0) && !q.ov;
	assign wr        = in_valid && in_ready;
	assign ld        = (q.cnt != '0) && (!q.ov || out_ready);

	// read data always leaves through the registered output stage
	always_comb begin
		d = q;
		if (out_ready && q.ov) begin
			d.ov = 1'h0;
		end
		if (ld) begin
			d.od = q.mem[q.rp];
			d.ov = 1'h1;
			d.rp = q.rp + 1'h1;
		end
		if (wr) begin
			d.mem[q.wp] = in_data;
			d.wp        = q.wp + 1'h1;
		end
		unique case ({wr, ld})
			2'h2: d.cnt = q.cnt + 1'h1;
			2'h1: d.cnt = q.cnt - 1'h1;
			default: d.cnt = q.cnt;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

/* verilog/dsk_cmd_core.sv */
`timescale 1ns/1ps
module dsk_cmd_core #(
	parameter int unsigned STEP_CYC = dsk_pkg::STEP_CYCLES
) (
	input  logic                  clk,
	input  logic                  rst_b,
	input  logic                  host_wr,
	input  logic [7:0]            host_byte,
	output logic                  cmd_ready,
	output logic                  res_valid,
	output logic [7:0]            res_data,
	input  logic                  res_taken,
	input  logic                  dma_mode,
	output logic                  dma_req,
	output logic                  pio_req,
	output logic                  xfer_valid,
	output logic [7:0]            xfer_data,
	input  logic                  xfer_ready,
	input  logic                  scan_valid,
	input  logic [7:0]            scan_data,
	output logic                  scan_ready,
	input  logic                  disk_valid,
	input  logic [7:0]            disk_data,
	output logic                  disk_ready,
	input  logic                  sector_done,
	input  logic                  id_valid,
	input  logic [7:0]            id_byte,
	input  logic                  track0,
	input  logic [7:0]            st1_flags,
	input  logic [7:0]            st2_flags,
	output dsk_pkg::dsk_drive_type drv,
	output logic [7:0]            present_track,
	output logic                  seek_end
);
	import dsk_pkg::*;

	dsk_core_type q, d;
	logic         f_in_valid;
	logic         f_in_ready;
	logic         f_ov;
	logic [7:0]   f_od;
	logic         f_out_ready;
	logic         f_empty;
	logic         streaming;
	logic         scanning;
	logic         scan_hs;
	logic [1:0]   unit;

	// opcode from the low five bits, flags are don't-care except bit 7, which relative seek requires
	function automatic dsk_kind_type dsk_decode(input logic [7:0] b);
		dsk_kind_type k;
		k = K_BAD;
		case (b[4:0])
			OPC_RD_DEL:  k = K_RD_DEL;
			OPC_RD_ID:   k = K_RD_ID;
			OPC_RD_TRK:  k = K_RD_TRK;
			OPC_RECAL:   k = K_RECAL;
			OPC_RSEEK:   k = b[BIT_RSEEK] ? K_RSEEK : K_BAD;
			OPC_SCAN_EQ: k = K_SCAN_EQ;
			OPC_SCAN_HE: k = K_SCAN_HE;
			default:     k = K_BAD;
		endcase
		return k;
	endfunction

	// total command length including the opcode byte
	function automatic logic [3:0] dsk_len(input dsk_kind_type k);
		logic [3:0] n;
		n = LEN_LONG;
		if (k == K_RD_ID || k == K_RECAL) begin
			n = LEN_DRIVE;
		end else if (k == K_RSEEK) begin
			n = LEN_RSEEK;
		end
		return n;
	endfunction

	function automatic logic dsk_is_scan(input dsk_kind_type k);
		return k == K_SCAN_EQ || k == K_SCAN_HE;
	endfunction

	// commands whose execution moves sector bytes through the buffer
	function automatic logic dsk_is_stream(input dsk_kind_type k);
		return k == K_RD_DEL || k == K_RD_TRK || dsk_is_scan(k);
	endfunction

	// result byte i: three status bytes then track, head, sector, size
	function automatic logic [7:0] dsk_res_byte(
		input dsk_core_type s,
		input logic [3:0]   i,
		input logic [7:0]   f1,
		input logic [7:0]   f2
	);
		logic [7:0]      st2;
		logic [3:0][7:0] chrn;
		logic [7:0]      b;
		st2  = f2;
		chrn = {s.prm[P_SIZE], s.prm[P_SECT], s.prm[P_HEAD], s.prm[P_TRACK]};
		if (s.kind == K_RD_ID) begin
			chrn = s.id;
		end
		if (dsk_is_scan(s.kind)) begin
			st2[ST2_SCAN_HIT]  = !s.miss;
			st2[ST2_SCAN_MISS] = s.miss;
		end
		unique case (i)
			4'h0: b = {5'h00, s.prm[P_UNIT][BIT_HEAD:0]};
			4'h1: b = f1;
			4'h2: b = st2;
			default: b = chrn[2'(i - RES_CHRN)];
		endcase
		return b;
	endfunction

	assign unit      = q.prm[P_UNIT][1:0];
	assign streaming = (q.st == S_EXEC) && dsk_is_stream(q.kind);
	assign scanning  = streaming && dsk_is_scan(q.kind);

	// drive data only enters while a transfer runs; a full buffer stalls the drive
	assign f_in_valid = disk_valid && streaming;
	assign disk_ready = f_in_ready && streaming;

	// reads hand buffered bytes to the host, scans pair them with host bytes
	assign xfer_valid  = f_ov && !dsk_is_scan(q.kind);
	assign xfer_data   = f_od;
	assign dma_req     = xfer_valid && dma_mode;
	assign pio_req     = xfer_valid && !dma_mode;
	assign scan_ready  = f_ov && scanning;
	assign scan_hs     = scan_ready && scan_valid;
	assign f_out_ready = dsk_is_scan(q.kind) ? scan_hs : xfer_ready;

	dsk_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (f_in_valid),
		.in_data   (disk_data),
		.in_ready  (f_in_ready),
		.out_valid (f_ov),
		.out_data  (f_od),
		.out_ready (f_out_ready),
		.empty     (f_empty)
	);

	// command sequencing: collect bytes, execute, return results
	always_comb begin
		d          = q;
		d.step_o   = 1'h0;
		d.seek_end = 1'h0;
		// step timer runs on between commands so back-to-back seeks keep the rate
		if (q.step_cnt != 16'h0000) begin
			d.step_cnt = q.step_cnt - 16'h0001;
		end
		unique case (q.st)
			S_IDLE: begin
				if (host_wr && dsk_decode(host_byte) != K_BAD) begin
					d.prm[0] = host_byte;
					d.kind   = dsk_decode(host_byte);
					d.idx    = 4'h1;
					d.st     = S_PARAM;
				end
			end
			S_PARAM: begin
				if (host_wr) begin
					d.prm[q.idx] = host_byte;
					if (q.kind == K_RECAL && q.idx == 4'h1) begin
						d.prm[P_UNIT] = {6'h00, host_byte[1:0]};
					end
					d.idx = q.idx + 4'h1;
					if (d.idx == dsk_len(q.kind)) begin
						d.done     = 1'h0;
						d.miss     = 1'h0;
						d.id_n     = 2'h0;
						if (q.kind == K_RECAL) begin
							d.steps = RECAL_MAX;
							d.dir   = 1'h0;
							d.st    = S_STEP;
						end else if (q.kind == K_RSEEK) begin
							d.steps = host_byte;
							d.dir   = q.prm[0][BIT_DIR];
							d.st    = S_STEP;
						end else begin
							d.st = S_EXEC;
						end
					end
				end
			end
			S_EXEC: begin
				d.done = q.done || sector_done;
				if (scan_hs) begin
					if (q.kind == K_SCAN_EQ && f_od != scan_data) begin
						d.miss = 1'h1;
					end
					if (q.kind == K_SCAN_HE && f_od < scan_data) begin
						d.miss = 1'h1;
					end
				end
				if (q.kind == K_RD_ID) begin
					if (id_valid) begin
						d.id[q.id_n] = id_byte;
						d.id_n       = q.id_n + 2'h1;
						if (q.id_n == ID_LAST) begin
							d.st    = S_RES;
							d.idx   = RES_FIRST;
							d.res_q = dsk_res_byte(d, RES_FIRST, st1_flags, st2_flags);
						end
					end
				end else if (q.done && f_empty) begin
					// wait for the buffer to drain so no sector byte is lost
					d.st    = S_RES;
					d.idx   = RES_FIRST;
					d.res_q = dsk_res_byte(d, RES_FIRST, st1_flags, st2_flags);
				end
			end
			S_STEP: begin
				if (q.kind == K_RECAL && track0) begin
					d.trk[unit] = 8'h00;
					d.seek_end  = 1'h1;
					d.st        = S_IDLE;
				end else if (q.steps == 8'h00) begin
					d.seek_end = 1'h1;
					d.st       = S_IDLE;
				end else if (q.step_cnt == 16'h0000) begin
					// one pulse per step period; track count follows the pulse
					d.step_o    = 1'h1;
					d.steps     = q.steps - 8'h01;
					d.step_cnt  = 16'(STEP_CYC - 1);
					d.trk[unit] = q.dir ? q.trk[unit] + 8'h01 : q.trk[unit] - 8'h01;
				end
			end
			S_RES: begin
				if (res_taken) begin
					if (q.idx == RES_LAST) begin
						d.st = S_IDLE;
					end else begin
						d.idx   = q.idx + 4'h1;
						d.res_q = dsk_res_byte(d, d.idx, st1_flags, st2_flags);
					end
				end
			end
			default: begin
				d.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
			q.st <= S_IDLE;
		end else begin
			q <= d;
		end
	end

	// host side handshakes
	assign cmd_ready = (q.st == S_IDLE) || (q.st == S_PARAM);
	assign res_valid = q.st == S_RES;
	assign res_data  = q.res_q;

	// head, unit and flags come from stored command bytes (MT, SK masked for read track); step and exec from state
	assign drv.head_select           = q.prm[P_UNIT][BIT_HEAD];
	assign drv.drive_unit_select     = unit;
	assign drv.step_pulse            = q.step_o;
	assign drv.step_dir              = q.dir;
	assign drv.exec_active           = q.st == S_EXEC;
	assign drv.double_density_select = q.prm[0][BIT_DD];
	assign drv.multi_track_flag      = q.prm[0][BIT_MT] && q.kind != K_RD_TRK;
	assign drv.skip_deleted_flag     = q.prm[0][BIT_SK] && q.kind != K_RD_TRK;
	assign present_track             = q.trk[unit];
	assign seek_end                  = q.seek_end;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// a read deleted opcode byte opens the parameter phase with the right command
	rd_del_decode_a: assert property (
		(q.st == S_IDLE && host_wr && host_byte[4:0] == OPC_RD_DEL)
		|=> (q.st == S_PARAM && q.kind == K_RD_DEL && q.idx == 4'h1))
		else $error("read deleted opcode not decoded");

	// execution never starts without a final write in the parameter phase
	exec_after_last_a: assert property (
		$rose(q.st == S_EXEC || q.st == S_STEP)
		|-> ($past(host_wr) && $past(q.st) == S_PARAM && $past(q.idx) + 4'h1 == $past(dsk_len(q.kind))))
		else $error("execution began before the last byte");

	// the result phase ends only after the seventh byte is taken
	res_seven_a: assert property (
		(q.st == S_RES && res_taken && q.idx != RES_LAST) |=> (q.st == S_RES))
		else $error("result phase ended early");

	// an unread result byte stays put
	res_hold_a: assert property (
		(res_valid && !res_taken) |=> (res_valid && $stable(res_data)))
		else $error("result byte changed while unread");

	// the fourth header byte completes read id and is kept
	id_capture_a: assert property (
		(q.st == S_EXEC && q.kind == K_RD_ID && id_valid && q.id_n == ID_LAST)
		|=> (q.st == S_RES && q.id[3] == $past(id_byte)))
		else $error("header byte not captured");

	// a read byte offered to the host stands until it is taken
	xfer_hold_a: assert property (
		(xfer_valid && !xfer_ready) |=> (xfer_valid && $stable(xfer_data)))
		else $error("read byte dropped before the host took it");

	// a differing byte in scan equal marks the scan as failed
	scan_eq_miss_a: assert property (
		(scan_hs && q.kind == K_SCAN_EQ && f_od != scan_data) |=> q.miss)
		else $error("scan equal mismatch not flagged");

	// a lower disk byte in scan high or equal marks a failure
	scan_he_miss_a: assert property (
		(scan_hs && q.kind == K_SCAN_HE && f_od < scan_data) |=> q.miss)
		else $error("scan high or equal miss not flagged");

	// each step pulse is followed by a quiet gap
	step_gap_a: assert property (
		drv.step_pulse |=> !drv.step_pulse [*8])
		else $error("step pulses too close");

	// recalibrate at track zero finishes with track count cleared
	recal_zero_a: assert property (
		(q.st == S_STEP && q.kind == K_RECAL && track0)
		|=> (seek_end && present_track == 8'h00 && q.st == S_IDLE && !res_valid))
		else $error("recalibrate did not end at track zero");
endmodule

/* bench/dsk_drive_model.sv */
`timescale 1ns/1ps
module dsk_drive_model (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   id_mode,
	input  wire logic                   slow,
	input  wire logic [7:0]             nbytes,
	input  wire dsk_pkg::dsk_drive_type drv,
	input  wire logic                   disk_ready,
	output logic                        disk_valid,
	output logic [7:0]                  disk_data,
	output logic                        sector_done,
	output logic                        id_valid,
	output logic [7:0]                  id_byte,
	output logic                        track0
);
	import dsk_pkg::*;
	logic [7:0] pos_q;
	logic [7:0] cnt_q;
	logic       gap_q;
	logic       run;
	// head moves one track per step pulse, inward when step_dir is high
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pos_q <= 8'h05;
		end else if (drv.step_pulse) begin
			pos_q <= drv.step_dir ? pos_q + 8'h01 : pos_q - 8'h01;
		end
	end
	// byte count restarts with each execution phase; slow mode idles a cycle per byte
	always_ff @(posedge clk) begin
		if (!rst_b || !run) begin
			cnt_q <= 8'h00;
			gap_q <= 1'b0;
		end else begin
			gap_q <= slow && disk_valid && disk_ready;
			if ((disk_valid && disk_ready) || id_valid) begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
	assign run         = drv.exec_active;
	assign track0      = (pos_q == 8'h00);
	assign disk_valid  = run && !id_mode && !gap_q && cnt_q < nbytes;
	assign sector_done = run && !id_mode && cnt_q == nbytes;
	// idle lines carry the inverse of the last byte so stale data never matches
	assign disk_data   = disk_valid ? 8'h30 + cnt_q : ~(8'h2F + cnt_q);
	assign id_valid    = run && id_mode && cnt_q < 8'h04;
	assign id_byte     = id_valid ? 8'h50 + cnt_q : ~(8'h4F + cnt_q);
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
	import dsk_pkg::*;
	localparam logic [55:0]     PRM  = 56'h11_01_03_02_09_1B_FF;
	localparam logic [0:3][7:0] SOP  = {8'h11, 8'hF1, 8'h1D, 8'h1D};
	localparam logic [0:3][7:0] SOFF = {8'h00, 8'h01, 8'hFF, 8'h01};
	localparam logic [0:3][7:0] SST2 = {8'h08, 8'h04, 8'h08, 8'h04};
	logic          clk, rst_b, host_wr, res_taken, dma_mode, xfer_ready, scan_valid;
	logic          cmd_ready, res_valid, dma_req, pio_req, xfer_valid, scan_ready;
	logic          disk_valid, disk_ready, sector_done, id_valid, track0, seek_end;
	logic          id_mode, slow, last_dir;
	logic [7:0]    host_byte, res_data, xfer_data, scan_data, disk_data, id_byte;
	logic [7:0]    st1_flags, st2_flags, present_track, nbytes;
	logic [7:0]    exp_b = 8'h30;
	logic [7:0]    rx_n = 8'h00;
	logic [7:0]    steps = 8'h00;
	dsk_drive_type drv;
	int            num_errors = 0;
	int            total_checks = 0;
	int            cyc = 0;

	dsk_cmd_core #(.STEP_CYC(10)) uut (
		.clk(clk), .rst_b(rst_b), .host_wr(host_wr), .host_byte(host_byte),
		.cmd_ready(cmd_ready), .res_valid(res_valid), .res_data(res_data),
		.res_taken(res_taken), .dma_mode(dma_mode), .dma_req(dma_req), .pio_req(pio_req),
		.xfer_valid(xfer_valid), .xfer_data(xfer_data), .xfer_ready(xfer_ready),
		.scan_valid(scan_valid), .scan_data(scan_data), .scan_ready(scan_ready),
		.disk_valid(disk_valid), .disk_data(disk_data), .disk_ready(disk_ready),
		.sector_done(sector_done), .id_valid(id_valid), .id_byte(id_byte),
		.track0(track0), .st1_flags(st1_flags), .st2_flags(st2_flags), .drv(drv),
		.present_track(present_track), .seek_end(seek_end));

	dsk_drive_model drive (
		.clk(clk), .rst_b(rst_b), .id_mode(id_mode), .slow(slow), .nbytes(nbytes),
		.drv(drv), .disk_ready(disk_ready), .disk_valid(disk_valid),
		.disk_data(disk_data), .sector_done(sector_done), .id_valid(id_valid),
		.id_byte(id_byte), .track0(track0));

	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// bounded wait, sampled mid-cycle where outputs have settled
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		@(negedge clk);
		while (s !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("wait", {7'h0, s}, 8'h01);
	endtask

	// one byte per cycle, back to back, starting only when the block is ready
	task automatic cmd(input logic [0:8][7:0] b, input int n);
		wait_hi(cmd_ready);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			host_wr   <= 1'b1;
			host_byte <= b[i];
		end
		@(posedge clk);
		host_wr <= 1'b0;
	endtask

	task automatic results(input logic [0:6][7:0] e);
		for (int i = 0; i < 7; i++) begin
			wait_hi(res_valid);
			chk("result", res_data, e[i]);
			@(posedge clk);
			res_taken <= 1'b1;
			@(posedge clk);
			res_taken <= 1'b0;
		end
		@(negedge clk);
		chk("res_end", {6'h0, res_valid, cmd_ready}, 8'h01);
	endtask

	task automatic seek(input logic [7:0] b0, input int len, input logic [7:0] n,
		input logic [7:0] trk);
		steps = 8'h00;
		// relative seeks also select head one; recalibrate has no head field
		cmd({b0, 5'h00, b0[7], 2'h0, n, 48'h0}, len);
		wait_hi(seek_end);
		chk("steps", steps, n);
		chk("track", present_track, trk);
		chk("dir", {7'h0, last_dir}, {7'h0, b0[6]});
		chk("head", {7'h0, drv.head_select}, {7'h0, b0[7]});
		chk("no_result", {7'h0, res_valid}, 8'h00);
	endtask

	function automatic logic [7:0] dflags();
		return {1'b0, drv.exec_active, drv.double_density_select, drv.multi_track_flag,
			drv.skip_deleted_flag, drv.head_select, drv.drive_unit_select};
	endfunction

	// host side of transfers, scan byte stream and step monitor
	always @(posedge clk) begin
		if (xfer_valid && xfer_ready) begin
			chk("xfer", xfer_data, exp_b);
			chk("req", {6'h0, dma_req, pio_req}, {6'h0, dma_mode, !dma_mode});
			exp_b = exp_b + 8'h01;
			rx_n  = rx_n + 8'h01;
		end
		if (scan_valid && scan_ready) begin
			scan_data <= scan_data + 8'h01;
		end
		if (drv.step_pulse) begin
			steps    = steps + 8'h01;
			last_dir = drv.step_dir;
		end
	end

	initial begin
		rst_b = 1'b0;
		{host_wr, res_taken, dma_mode, xfer_ready, scan_valid, id_mode, slow} = 7'h0;
		{host_byte, scan_data} = 16'h0;
		nbytes = 8'h04;
		st1_flags = 8'h21;
		st2_flags = 8'h40;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk("idle", {cmd_ready, res_valid, xfer_valid, disk_ready, seek_end, 3'h0}, 8'h80);
		chk("drv_idle", dflags(), 8'h00);
		$display("test reset done");
		// read deleted, all flags set, DMA handover
		@(posedge clk);
		dma_mode   <= 1'b1;
		xfer_ready <= 1'b1;
		cmd({8'hEC, 8'h05, PRM}, 9);
		@(negedge clk);
		chk("drv_del", dflags(), 8'h7D);
		results({8'h05, 8'h21, 8'h40, 8'h11, 8'h01, 8'h03, 8'h02});
		chk("count", rx_n, 8'h04);
		$display("test read_deleted done");
		// read track, slow drive, host stalls until the buffer refuses
		@(posedge clk);
		{dma_mode, xfer_ready, slow} <= 3'b001;
		nbytes <= 8'h28;
		rx_n = 8'h00;
		exp_b = 8'h30;
		cmd({8'h42, 8'h00, PRM}, 9);
		@(negedge clk);
		chk("drv_trk", dflags(), 8'h60);
		repeat (120) @(negedge clk);
		chk("full", {4'h0, disk_valid, disk_ready, dma_req, pio_req}, 8'h09);
		@(posedge clk);
		host_wr   <= 1'b1;
		host_byte <= 8'h4A;
		@(posedge clk);
		host_wr    <= 1'b0;
		xfer_ready <= 1'b1;
		results({8'h00, 8'h21, 8'h40, 8'h11, 8'h01, 8'h03, 8'h02});
		chk("count", rx_n, 8'h28);
		$display("test read_track done");
		// read id, header bytes come from the drive
		@(posedge clk);
		{id_mode, slow} <= 2'b10;
		cmd({8'h4A, 8'h06, PRM}, 2);
		@(negedge clk);
		chk("drv_id", dflags(), 8'h66);
		results({8'h06, 8'h21, 8'h40, 8'h50, 8'h51, 8'h52, 8'h53});
		$display("test read_id done");
		// scans: equal hit, equal miss, high-or-equal hit and miss
		@(posedge clk);
		{id_mode, st2_flags, nbytes} <= {1'b0, 8'h00, 8'h04};
		rx_n = 8'h00;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			scan_data  <= 8'h30 + SOFF[k];
			scan_valid <= 1'b1;
			cmd({SOP[k], 8'h01, PRM}, 9);
			results({8'h01, 8'h21, SST2[k], 8'h11, 8'h01, 8'h03, 8'h02});
		end
		@(posedge clk);
		scan_valid <= 1'b0;
		chk("scan_no_xfer", rx_n, 8'h00);
		$display("test scans done");
		// seek opcode without bit 7, recalibrate, relative seeks both ways
		cmd({8'h0F, PRM, 8'h00}, 1);
		repeat (3) @(negedge clk);
		chk("ignored", {6'h0, cmd_ready, drv.exec_active}, 8'h02);
		seek(8'h07, 2, 8'h05, 8'h00);
		seek(8'hCF, 3, 8'h03, 8'h03);
		seek(8'h8F, 3, 8'h01, 8'h02);
		$display("test seeks done");
		wrap_up();
	end
endmodule
